/* core/cio_pkg.sv */
// Package for the configurable I/O port logic: widths, register offsets, driver type codes, timing counts.
// Assumes a byte-wide special function register port from the CPU side.
package cio_pkg;
   localparam int PORT_WIDE_W = 8;
   localparam int PORT_NARROW_W = 2;
   localparam int PIN_COUNT = 18;
   localparam int CLOCK_MHZ = 100;
   // Glitch suppression window in ns; a level must hold this long to pass
   localparam int GLITCH_NS = 50;
   localparam int GLITCH_CYCLES = (GLITCH_NS * CLOCK_MHZ + 999) / 1000;
   // Register offsets, arbitrary in this block's own space
   localparam logic [7:0] ADDR_P0_LATCH = 8'h00;
   localparam logic [7:0] ADDR_P1_LATCH = 8'h01;
   localparam logic [7:0] ADDR_P3_LATCH = 8'h02;
   localparam logic [7:0] ADDR_P0_CFG1 = 8'h03;
   localparam logic [7:0] ADDR_P0_CFG2 = 8'h04;
   localparam logic [7:0] ADDR_P1_CFG1 = 8'h05;
   localparam logic [7:0] ADDR_P1_CFG2 = 8'h06;
   localparam logic [7:0] ADDR_P3_CFG1 = 8'h07;
   localparam logic [7:0] ADDR_P3_CFG2 = 8'h08;
   localparam logic [7:0] ADDR_P0_DIG_DIS = 8'h09;
   localparam logic [7:0] ADDR_P0_IN = 8'h0A;
   localparam logic [7:0] ADDR_P1_IN = 8'h0B;
   localparam logic [7:0] ADDR_P3_IN = 8'h0C;
   localparam logic [7:0] ADDR_PIN_AVAIL = 8'h0D;
   // Driver type {cfg1,cfg2}
   localparam logic [1:0] TYPE_QUASI = 2'h0;
   localparam logic [1:0] TYPE_PUSH = 2'h1;
   localparam logic [1:0] TYPE_INPUT = 2'h2;
   localparam logic [1:0] TYPE_OPEN = 2'h3;
   // Reset values: cfg1 all ones, cfg2 all zeros selects input-only
   localparam logic [7:0] CFG1_RESET = 8'hFF;
   localparam logic [7:0] CFG2_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'hFF;
   localparam logic [7:0] DIG_DIS_MASK = 8'h3E;
   localparam int RESET_PIN = 5;
   localparam int BUS_CLK_PIN = 2;
   localparam int BUS_DATA_PIN = 3;
   // Clock source option codes
   localparam logic [1:0] CLK_INTERNAL = 2'h0;
   localparam logic [1:0] CLK_EXT_INPUT = 2'h1;
   localparam logic [1:0] CLK_CRYSTAL = 2'h2;
   localparam logic [4:0] PINS_BASE = 5'h12;
endpackage

/* core/cio_pin_filter.sv */
// One pin's input path: glitch suppression followed by a registered output.
// Assumes the pin level is already synchronous to i_clock.
`timescale 1ns/1ns
module cio_pin_filter #(
   parameter int CYCLES = 5
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Pin level in, filtered level out
   input wire logic i_level,
   output logic o_level
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] count_reg;
   logic level_reg;
   wire differs = i_level != level_reg;
   wire settled = count_reg == CW'(CYCLES - 1);
   if (CYCLES < 1) begin : g_bad_cycles
      $error("CYCLES must be at least one");
   end
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         count_reg <= '0;
         level_reg <= 1'b1;
      end else if (!differs) begin
         count_reg <= '0;
      end else if (settled) begin
         count_reg <= '0;
         level_reg <= i_level;
      end else begin
         count_reg <= count_reg + CW'(1);
      end
   end
   assign o_level = level_reg;
endmodule // cio_pin_filter

/* core/cio_port_logic.sv */
// Configurable I/O port logic: two 8-bit ports and one 2-bit port with per-pin driver types.
// Assumes the CPU's byte-wide register port and pads that resolve weak/strong drive externally.
`timescale 1ns/1ns
module cio_port_logic #(
   parameter int FILTER_CYCLES = cio_pkg::GLITCH_CYCLES
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Register port
   input wire logic i_reg_write,
   input wire logic i_reg_read,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // Options
   input wire logic i_reset_pin_function_enable,
   input wire logic i_power_up,
   input wire logic [1:0] i_clock_source,
   // Pin levels
   input wire logic [7:0] i_p0_pin,
   input wire logic [7:0] i_p1_pin,
   input wire logic [1:0] i_p3_pin,
   // Pin drivers: strong pull-down, strong pull-up, weak pull-up
   output logic [17:0] o_pull_down,
   output logic [17:0] o_pull_up_strong,
   output logic [17:0] o_pull_up_weak,
   // Filtered digital inputs and external reset request
   output logic [17:0] o_pin_in,
   output logic o_external_reset_n
);
   localparam int N = cio_pkg::PIN_COUNT;
   localparam int W = cio_pkg::PORT_WIDE_W;
   localparam int RP = W + cio_pkg::RESET_PIN;
   localparam int SCLP = W + cio_pkg::BUS_CLK_PIN;
   localparam int SDAP = W + cio_pkg::BUS_DATA_PIN;
   localparam logic [N-1:0] LATCH_INIT = {cio_pkg::LATCH_RESET[1:0], cio_pkg::LATCH_RESET, cio_pkg::LATCH_RESET};
   localparam logic [N-1:0] CFG1_INIT = {cio_pkg::CFG1_RESET[1:0], cio_pkg::CFG1_RESET, cio_pkg::CFG1_RESET};
   localparam logic [N-1:0] CFG2_INIT = {cio_pkg::CFG2_RESET[1:0], cio_pkg::CFG2_RESET, cio_pkg::CFG2_RESET};
   // Refuse layouts and filter lengths that the packing below cannot serve
   if (N != 2 * W + cio_pkg::PORT_NARROW_W) begin : g_bad_count
      $error("pin count mismatch");
   end
   if (FILTER_CYCLES < 1) begin : g_bad_filter
      $error("filter needs at least one cycle");
   end
   if (cio_pkg::PINS_BASE != 5'(N)) begin : g_bad_base
      $error("available pin base differs from pin count");
   end
   // Latches and configuration, packed port 0 low, port 1, port 3 high
   logic [N-1:0] latch_reg;
   logic [N-1:0] cfg1_reg;
   logic [N-1:0] cfg2_reg;
   logic [7:0] port0_digital_input_disable_reg;
   logic [N-1:0] pull_down_reg, pull_up_strong_reg, pull_up_weak_reg;
   logic [N-1:0] pin_in_reg;
   logic [7:0] rdata_reg;
   logic ext_reset_n_reg;
   logic [N-1:0] filtered;
   wire [N-1:0] raw_pins = {i_p3_pin, i_p1_pin, i_p0_pin};
   // Write strobes
   wire wr_l0 = i_reg_write && i_reg_addr == cio_pkg::ADDR_P0_LATCH;
   wire wr_l1 = i_reg_write && i_reg_addr == cio_pkg::ADDR_P1_LATCH;
   wire wr_l3 = i_reg_write && i_reg_addr == cio_pkg::ADDR_P3_LATCH;
   wire wr_a0 = i_reg_write && i_reg_addr == cio_pkg::ADDR_P0_CFG1;
   wire wr_b0 = i_reg_write && i_reg_addr == cio_pkg::ADDR_P0_CFG2;
   wire wr_a1 = i_reg_write && i_reg_addr == cio_pkg::ADDR_P1_CFG1;
   wire wr_b1 = i_reg_write && i_reg_addr == cio_pkg::ADDR_P1_CFG2;
   wire wr_a3 = i_reg_write && i_reg_addr == cio_pkg::ADDR_P3_CFG1;
   wire wr_b3 = i_reg_write && i_reg_addr == cio_pkg::ADDR_P3_CFG2;
   wire wr_dd = i_reg_write && i_reg_addr == cio_pkg::ADDR_P0_DIG_DIS;
   // A write replaces one port's byte, the other ports hold
   wire [N-1:0] latch_next = {wr_l3 ? i_reg_wdata[1:0] : latch_reg[N-1:2*W],
      wr_l1 ? i_reg_wdata : latch_reg[2*W-1:W], wr_l0 ? i_reg_wdata : latch_reg[W-1:0]};
   wire [N-1:0] cfg1_next = {wr_a3 ? i_reg_wdata[1:0] : cfg1_reg[N-1:2*W],
      wr_a1 ? i_reg_wdata : cfg1_reg[2*W-1:W], wr_a0 ? i_reg_wdata : cfg1_reg[W-1:0]};
   wire [N-1:0] cfg2_next = {wr_b3 ? i_reg_wdata[1:0] : cfg2_reg[N-1:2*W],
      wr_b1 ? i_reg_wdata : cfg2_reg[2*W-1:W], wr_b0 ? i_reg_wdata : cfg2_reg[W-1:0]};
   wire [7:0] dig_dis_next = wr_dd ? (i_reg_wdata & cio_pkg::DIG_DIS_MASK) : port0_digital_input_disable_reg;
   // Effective type per pin with fixed restrictions
   logic [N-1:0] eff_cfg1, eff_cfg2;
   always_comb begin
      eff_cfg1 = cfg1_reg;
      eff_cfg2 = cfg2_reg;
      eff_cfg1[RP] = 1'b1;
      eff_cfg2[RP] = 1'b0;
      // Bus pins: only the cfg2 bit chooses between input-only and open-drain
      eff_cfg1[SCLP] = 1'b1;
      eff_cfg1[SDAP] = 1'b1;
   end
   // Driver decode; relies on an outside pull-up for open-drain high
   logic [N-1:0] pd_next, pus_next, puw_next;
   always_comb begin
      for (int k = 0; k < N; k++) begin
         case ({eff_cfg1[k], eff_cfg2[k]})
            cio_pkg::TYPE_QUASI: begin
               pd_next[k] = !latch_reg[k];
               pus_next[k] = 1'b0;
               puw_next[k] = latch_reg[k];
            end
            cio_pkg::TYPE_PUSH: begin
               pd_next[k] = !latch_reg[k];
               pus_next[k] = latch_reg[k];
               puw_next[k] = 1'b0;
            end
            cio_pkg::TYPE_OPEN: begin
               pd_next[k] = !latch_reg[k];
               pus_next[k] = 1'b0;
               puw_next[k] = 1'b0;
            end
            default: begin
               pd_next[k] = 1'b0;
               pus_next[k] = 1'b0;
               puw_next[k] = 1'b0;
            end
         endcase
      end
   end
   // Input filters on every pin regardless of type
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_filt
         cio_pin_filter #(.CYCLES(FILTER_CYCLES)) u_filt (
            .i_clock(i_clock),
            .i_srst(i_srst),
            .i_level(raw_pins[g]),
            .o_level(filtered[g])
         );
      end
   endgenerate
   // Disabled port 0 inputs read as zero
   wire [N-1:0] dis_mask = {{(N-W){1'b0}}, port0_digital_input_disable_reg};
   wire [N-1:0] pin_in_next = filtered & ~dis_mask;
   // Reset pin function: power-up forces it, otherwise the enable bit decides
   // Filters reset high, so no false request follows a reset
   wire rst_fn = i_power_up || i_reset_pin_function_enable;
   wire ext_reset_n_next = rst_fn ? filtered[RP] : 1'b1;
   // Pins released for general use
   logic [4:0] avail;
   always_comb begin
      avail = cio_pkg::PINS_BASE;
      if (i_reset_pin_function_enable) avail = avail - 5'h01;
      if (i_clock_source == cio_pkg::CLK_EXT_INPUT) avail = avail - 5'h01;
      else if (i_clock_source == cio_pkg::CLK_CRYSTAL) avail = avail - 5'h02;
   end
   // Read mux
   logic [7:0] rd_next;
   always_comb begin
      case (i_reg_addr)
         cio_pkg::ADDR_P0_LATCH: rd_next = latch_reg[W-1:0];
         cio_pkg::ADDR_P1_LATCH: rd_next = latch_reg[2*W-1:W];
         cio_pkg::ADDR_P3_LATCH: rd_next = {6'h00, latch_reg[N-1:2*W]};
         cio_pkg::ADDR_P0_CFG1: rd_next = cfg1_reg[W-1:0];
         cio_pkg::ADDR_P0_CFG2: rd_next = cfg2_reg[W-1:0];
         cio_pkg::ADDR_P1_CFG1: rd_next = eff_cfg1[2*W-1:W];
         cio_pkg::ADDR_P1_CFG2: rd_next = eff_cfg2[2*W-1:W];
         cio_pkg::ADDR_P3_CFG1: rd_next = {6'h00, cfg1_reg[N-1:2*W]};
         cio_pkg::ADDR_P3_CFG2: rd_next = {6'h00, cfg2_reg[N-1:2*W]};
         cio_pkg::ADDR_P0_DIG_DIS: rd_next = port0_digital_input_disable_reg;
         cio_pkg::ADDR_P0_IN: rd_next = pin_in_reg[W-1:0];
         cio_pkg::ADDR_P1_IN: rd_next = pin_in_reg[2*W-1:W];
         cio_pkg::ADDR_P3_IN: rd_next = {6'h00, pin_in_reg[N-1:2*W]};
         cio_pkg::ADDR_PIN_AVAIL: rd_next = {3'h0, avail};
         default: rd_next = 8'h00;
      endcase
   end
   // Configuration state; reset leaves every pin input-only
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         latch_reg <= LATCH_INIT;
         cfg1_reg <= CFG1_INIT;
         cfg2_reg <= CFG2_INIT;
         port0_digital_input_disable_reg <= 8'h00;
      end else begin
         latch_reg <= latch_next;
         cfg1_reg <= cfg1_next;
         cfg2_reg <= cfg2_next;
         port0_digital_input_disable_reg <= dig_dis_next;
      end
   end
   // Driver enables come from flops so the pads never see decode glitches
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         pull_down_reg <= '0;
         pull_up_strong_reg <= '0;
         pull_up_weak_reg <= '0;
         pin_in_reg <= '0;
         rdata_reg <= 8'h00;
         ext_reset_n_reg <= 1'b1;
      end else begin
         pull_down_reg <= pd_next;
         pull_up_strong_reg <= pus_next;
         pull_up_weak_reg <= puw_next;
         pin_in_reg <= pin_in_next;
         rdata_reg <= i_reg_read ? rd_next : rdata_reg;
         ext_reset_n_reg <= ext_reset_n_next;
      end
   end
   assign o_pull_down = pull_down_reg;
   assign o_pull_up_strong = pull_up_strong_reg;
   assign o_pull_up_weak = pull_up_weak_reg;
   assign o_pin_in = pin_in_reg;
   assign o_reg_rdata = rdata_reg;
   assign o_external_reset_n = ext_reset_n_reg;
endmodule // cio_port_logic

/* verification/cio_port_monitor.sv */
// Checker for the configurable I/O port logic, bound to its top module.
// Assumes the top module's ports and a single clock domain.
`timescale 1ns/1ns
module cio_port_monitor #(
   parameter int FILTER_CYCLES = 5
) (
   // Clock, reset, register port
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_reg_read,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] o_reg_rdata,
   // Options and pins
   input wire logic i_reset_pin_function_enable,
   input wire logic i_power_up,
   input wire logic [1:0] i_clock_source,
   input wire logic [7:0] i_p1_pin,
   // Drivers and inputs
   input wire logic [17:0] o_pull_down,
   input wire logic [17:0] o_pull_up_strong,
   input wire logic [17:0] o_pull_up_weak,
   input wire logic [17:0] o_pin_in,
   input wire logic o_external_reset_n
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_srst);
   logic [4:0] avail_exp;
   assign avail_exp = cio_pkg::PINS_BASE - 5'(i_reset_pin_function_enable)
      - (i_clock_source == cio_pkg::CLK_EXT_INPUT ? 5'h01 : (i_clock_source == cio_pkg::CLK_CRYSTAL ? 5'h02 : 5'h00));
   sequence s_count_read;
      i_reg_read && i_reg_addr == cio_pkg::ADDR_PIN_AVAIL;
   endsequence
   sequence s_option_off;
      (!i_reset_pin_function_enable && !i_power_up) [*2];
   endsequence
   a_pin_count_read: assert property (s_count_read |=> o_reg_rdata == {3'h0, $past(avail_exp)})
      else $error("available pin count wrong");
   a_reset_req_off: assert property (s_option_off |=> o_external_reset_n)
      else $error("reset request while function off");
   a_glitch_block: assert property ($rose(o_pin_in[8]) |-> $past(i_p1_pin[0], 2))
      else $error("short pulse passed the filter");
   a_reset_quiet: assert property ($past(i_srst) |-> (o_pull_down | o_pull_up_strong | o_pull_up_weak) == 18'h0
      && o_pin_in == 18'h0 && o_external_reset_n)
      else $error("drivers active after reset");
   a_reset_pin_idle: assert property (!(o_pull_down[13] || o_pull_up_strong[13] || o_pull_up_weak[13]))
      else $error("reset pin driven");
   a_bus_pins_open: assert property ((o_pull_up_strong[11:10] | o_pull_up_weak[11:10]) == 2'h0)
      else $error("bus pin pulled up");
   a_weak_high_only: assert property ((o_pull_up_weak & (o_pull_up_strong | o_pull_down)) == 18'h0)
      else $error("weak pull-up with other driver");
   a_push_no_fight: assert property ((o_pull_down & o_pull_up_strong) == 18'h0)
      else $error("strong high and low together");
endmodule // cio_port_monitor

bind cio_port_logic cio_port_monitor #(.FILTER_CYCLES(FILTER_CYCLES)) u_mon (.i_clock(i_clock), .i_srst(i_srst),
   .i_reg_read(i_reg_read), .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
   .i_reset_pin_function_enable(i_reset_pin_function_enable), .i_power_up(i_power_up),
   .i_clock_source(i_clock_source), .i_p1_pin(i_p1_pin), .o_pull_down(o_pull_down),
   .o_pull_up_strong(o_pull_up_strong), .o_pull_up_weak(o_pull_up_weak), .o_pin_in(o_pin_in),
   .o_external_reset_n(o_external_reset_n));

/* verification/cio_pin_partner.sv */
// Outside circuitry on the 18 pins: fitted pull-ups and parts that pull low.
// Assumes driver enables from the port logic; unloaded released pins float.
`timescale 1ns/1ns
module cio_pin_partner (
   // Clock
   input wire logic i_clock,
   // Port logic drivers
   input wire logic [17:0] i_pull_down,
   input wire logic [17:0] i_pull_up,
   // Outside party controls
   input wire logic [17:0] i_pullup_fit,
   input wire logic [17:0] i_force_low,
   // Resolved pin levels
   output logic [17:0] o_pin
);
   logic float_reg;
   always_ff @(posedge i_clock) begin
      float_reg <= (float_reg !== 1'b1);
   end
   // Released pins without a fitted pull-up wander every cycle
   assign o_pin = ~(i_pull_down | i_force_low) & (i_pull_up | i_pullup_fit | {18{float_reg}});
endmodule // cio_pin_partner

/* verification/testbench.sv */
// Self-checking bench for the configurable I/O port logic.
// Assumes the pin partner model and the bound checker.
`timescale 1ns/1ns
module testbench;
   logic i_clock = 1'b0;
   logic i_srst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic reset_pin_function_enable = 1'b0;
   logic pwr = 1'b0;
   logic [1:0] csrc = 2'h0;
   logic [17:0] fit = 18'h3FFFF;
   logic [17:0] low = 18'h00000;
   logic [17:0] pd, pus, puw, pin_in, pins;
   logic [7:0] rdata;
   logic rst_n;
   int fail_count = 0;
   int checks = 0;
   always #5 i_clock = ~i_clock;
   cio_port_logic #(.FILTER_CYCLES(3)) u_dut (.i_clock(i_clock), .i_srst(i_srst), .i_reg_write(wr),
      .i_reg_read(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_reset_pin_function_enable(reset_pin_function_enable), .i_power_up(pwr), .i_clock_source(csrc), .i_p0_pin(pins[7:0]),
      .i_p1_pin(pins[15:8]), .i_p3_pin(pins[17:16]), .o_pull_down(pd), .o_pull_up_strong(pus),
      .o_pull_up_weak(puw), .o_pin_in(pin_in), .o_external_reset_n(rst_n));
   cio_pin_partner u_far (.i_clock(i_clock), .i_pull_down(pd), .i_pull_up(pus | puw), .i_pullup_fit(fit),
      .i_force_low(low), .o_pin(pins));
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      chk(18'(rdata), 18'(exp));
      tick(1);
   endtask
   task automatic do_reset;
      i_srst = 1'b1;
      tick(5);
      i_srst = 1'b0;
      tick(1);
      chk(pd | pus | puw, 18'h00000);
      rd_chk(cio_pkg::ADDR_P0_CFG1, 8'hFF);
      rd_chk(cio_pkg::ADDR_P0_CFG2, 8'h00);
      rd_chk(cio_pkg::ADDR_P0_DIG_DIS, 8'h00);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      do_reset();
      // Every driver type on port 0
      for (int t = 0; t < 4; t++) begin
         wr_reg(cio_pkg::ADDR_P0_LATCH, 8'hA5);
         wr_reg(cio_pkg::ADDR_P0_CFG1, {8{t[1]}});
         wr_reg(cio_pkg::ADDR_P0_CFG2, {8{t[0]}});
         tick(2);
         chk(pd[7:0], (t == 2) ? 18'h0 : 18'h5A);
         chk(pus[7:0], (t == 1) ? 18'hA5 : 18'h0);
         chk(puw[7:0], (t == 0) ? 18'hA5 : 18'h0);
      end
      // Port 1 asked for push-pull everywhere
      wr_reg(cio_pkg::ADDR_P1_LATCH, 8'h00);
      wr_reg(cio_pkg::ADDR_P1_CFG1, 8'h00);
      wr_reg(cio_pkg::ADDR_P1_CFG2, 8'hFF);
      tick(2);
      chk(pd[15:8], 18'hDF);
      wr_reg(cio_pkg::ADDR_P1_LATCH, 8'hFF);
      tick(2);
      chk(pus[15:8], 18'hD3);
      rd_chk(cio_pkg::ADDR_P1_CFG1, 8'h2C);
      rd_chk(cio_pkg::ADDR_P1_CFG2, 8'hDF);
      wr_reg(cio_pkg::ADDR_P3_CFG1, 8'h00);
      wr_reg(cio_pkg::ADDR_P3_LATCH, 8'h01);
      tick(2);
      chk({puw[17:16], pd[17:16]}, 18'h6);
      rd_chk(cio_pkg::ADDR_P3_LATCH, 8'h01);
      // Analog pins lose their digital input
      wr_reg(cio_pkg::ADDR_P0_LATCH, 8'hFF);
      wr_reg(cio_pkg::ADDR_P0_CFG1, 8'hFF);
      wr_reg(cio_pkg::ADDR_P0_CFG2, 8'h00);
      wr_reg(cio_pkg::ADDR_P0_DIG_DIS, 8'hFF);
      rd_chk(cio_pkg::ADDR_P0_DIG_DIS, 8'h3E);
      chk(pd[7:0] | pus[7:0] | puw[7:0], 18'h0);
      tick(8);
      chk(pin_in[7:0], 18'hC1);
      rd_chk(cio_pkg::ADDR_P0_IN, 8'hC1);
      rd_chk(cio_pkg::ADDR_P3_IN, 8'h01);
      // Short and long low pulses on an input-only pin
      wr_reg(cio_pkg::ADDR_P1_CFG1, 8'hFF);
      wr_reg(cio_pkg::ADDR_P1_CFG2, 8'h00);
      low = 18'h00100;
      tick(1);
      low = 18'h00000;
      tick(6);
      chk(pin_in[8], 18'h1);
      low = 18'h00100;
      tick(8);
      chk(pin_in[8], 18'h0);
      rd_chk(cio_pkg::ADDR_P1_IN, 8'hFE);
      low = 18'h02000;
      reset_pin_function_enable = 1'b1;
      tick(8);
      chk(rst_n, 18'h0);
      reset_pin_function_enable = 1'b0;
      tick(4);
      chk(rst_n, 18'h1);
      pwr = 1'b1;
      tick(4);
      chk(rst_n, 18'h0);
      pwr = 1'b0;
      low = 18'h00000;
      for (int e = 0; e < 2; e++) begin
         for (int s = 0; s < 3; s++) begin
            reset_pin_function_enable = e[0];
            csrc = s[1:0];
            rd_chk(cio_pkg::ADDR_PIN_AVAIL, 8'h12 - 8'(e) - 8'(s));
         end
      end
      do_reset();
      report_and_stop();
   end
endmodule // testbench
